// File: bench/dpdc_host.sv
// Host model: drives the serial command port, one frame per call.
// Assumes frames are started from the testbench on the reference clock.
`timescale 1ns/1ps
module dpdc_host (
  // Clock
  input  wire logic i_ref_clk,
  // Serial port
  input  wire logic i_sdo,
  input  wire logic i_sdo_oe_b,
  output logic      o_csb_b,
  output logic      o_sclk,
  output logic      o_sdi
);
  initial begin
    o_csb_b = 1'b1;
    o_sclk  = 1'b0;
    o_sdi   = 1'b0;
  end

  // Four clocks per sclk phase; read bits taken late in the high phase
  task automatic xfer(input logic rw, input logic [2:0] a,
                      input logic [7:0] d, output logic [4:0] q);
    logic [15:0] fr;
    fr = {d, 4'h0, a, rw};
    q  = 5'h00;
    @(negedge i_ref_clk);
    o_csb_b = 1'b0;
    for (int i = 0; i < 16; i++) begin
      o_sclk = 1'b0;
      o_sdi  = fr[i];
      repeat (4) @(negedge i_ref_clk);
      o_sclk = 1'b1;
      repeat (3) @(negedge i_ref_clk);
      if (i >= 8 && i < 13) begin
        q[i-8] = i_sdo_oe_b ? 1'bx : i_sdo;
      end
      @(negedge i_ref_clk);
    end
    o_sclk = 1'b0;
    repeat (4) @(negedge i_ref_clk);
    o_csb_b = 1'b1;
    // Released data line must not keep its last value
    o_sdi = ~o_sdi;
    repeat (6) @(negedge i_ref_clk);
  endtask
endmodule

// File: bench/testbench.sv
// Self-checking bench: host model writes registers, outputs are compared.
// Assumes master strap high and first PLL enabled, except one data-mode step that drops both.
`timescale 1ns/1ps
module testbench;
  import dpdc_pkg::*;
  logic        i_ref_clk = 1'b0;
  logic        i_rst_b   = 1'b0;
  logic        i_fin     = 1'b0;
  logic [3:0]  mode      = 4'h0;
  logic        csb_b, sclk, sdi, sdo, sdo_oe_b, en2, sync, err;
  logic        master    = 1'b1;
  logic        en1       = 1'b1;
  logic [15:0] ratio, f1, f2;
  logic [5:0]  k1, k2;
  logic [4:0]  dly, m1, m2, pre;
  dpdc_rate_e  r1, r2;
  logic [76:0] exp_q[$];
  logic [3:0]  ml [3] = '{4'h0, 4'h2, 4'h8};
  logic [4:0]  dc [4] = '{5'h00, 5'h01, 5'h12, 5'h1F};
  int          failures, num_checks, cyc;
  int          seed = 32'h652012D9;
  event        ev;

  initial forever #20 i_ref_clk = ~i_ref_clk;

  dpdc_host host_u (.i_ref_clk(i_ref_clk), .i_sdo(sdo),
    .i_sdo_oe_b(sdo_oe_b), .o_csb_b(csb_b), .o_sclk(sclk), .o_sdi(sdi));

  dpdc_top dut_u (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b),
    .i_csb_b(csb_b), .i_sclk(sclk), .i_sdi(sdi), .o_sdo(sdo),
    .o_sdo_oe_b(sdo_oe_b), .i_fin(i_fin), .i_master_sel(master),
    .i_operating_mode_field(mode), .i_first_pll_enable(en1),
    .o_second_pll_enable(en2), .o_prescaler_ratio(ratio), .o_sync(sync),
    .o_first_pll_rate(r1), .o_second_pll_rate(r2), .o_first_pll_k(k1),
    .o_second_pll_k(k2), .o_first_pll_freq(f1), .o_second_pll_freq(f2),
    .o_sync_delay_cyc(dly), .o_reverse_cfg_err(err));

  function automatic logic [15:0] frq(input logic [4:0] c);
    case (mode)
      4'h2:    return 16'h0280 * (c + 16'h0001);
      4'h5:    return (c == 5'h00) ? 16'h000C :
                      (c > 5'h12) ? 16'h01B0 : 16'h0018 * c;
      4'h6:    return 16'h3C50;
      default: return 16'h0230 * (c + 16'h0001);
    endcase
  endfunction

  function automatic logic [76:0] exp_v();
    logic [15:0] r;
    logic [9:0]  t;
    logic [4:0]  rk;
    r = (mode[3] ? 16'h0100 : 16'h00C1) * (pre[4:1] + 16'h0001);
    if (mode == 4'h6) r = 16'h0007;
    if (!master) r = 16'h0001;
    t = 10'h000;
    if (mode == 4'h2) t = (DLY64_NS[m1] + 10'h027) / 10'h028;
    if (mode[2:0] == 3'h0) t = (DLY56_NS[m1] + 10'h027) / 10'h028;
    case (mode)
      4'h2:    rk = RATE_K64;
      4'h5:    rk = RATE_DATA;
      4'h6:    rk = RATE_T1;
      default: rk = RATE_K56;
    endcase
    return {pre[0], r, {1'b0, m1} + 6'h01, {1'b0, m2} + 6'h01,
            en1 ? frq(m1) : 16'h0000, pre[0] ? frq(m2) : 16'h0000,
            t[4:0], rk, rk,
            (mode[2:1] == 2'h3 && (m1 & m2) != 5'h1F)};
  endfunction

  task automatic wr(input logic [2:0] a, input logic [4:0] d);
    logic [4:0] q;
    host_u.xfer(1'b0, a, {3'h0, d}, q);
    repeat (8) @(negedge i_ref_clk);
  endtask

  task automatic rd(input logic [2:0] a, input logic [4:0] e);
    logic [4:0] q;
    host_u.xfer(1'b1, a, 8'h00, q);
    num_checks++;
    if (q !== e) begin
      failures++;
      $display("BAD %0t read of %0h", $time, a);
    end
  endtask

  task automatic cfg();
    wr(3'h1, pre);
    wr(3'h2, m1);
    wr(3'h3, m2);
    exp_q.push_back(exp_v());
    -> ev;
  endtask

  // Sync period measured between two rising edges
  task automatic chk_sync(input time e);
    time t0;
    @(posedge sync);
    t0 = $time;
    @(posedge sync);
    num_checks++;
    if ($time - t0 != e) begin
      failures++;
      $display("BAD %0t sync period wrong", $time);
    end
  endtask

  always @(ev) begin
    while (exp_q.size() > 0) begin
      num_checks++;
      if ({en2, ratio, k1, k2, f1, f2, dly, r1, r2, err}
          !== exp_q.pop_front()) begin
        failures++;
        $display("BAD %0t settings differ", $time);
      end
    end
  end

  always @(posedge i_ref_clk) cyc <= cyc + 1;
  always @(negedge i_ref_clk) i_fin <= cyc[2];
  always @(posedge i_ref_clk) begin
    if (cyc == 20000) begin
      failures++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    repeat (3) @(negedge i_ref_clk);
    i_rst_b = 1'b1;
    repeat (2) @(negedge i_ref_clk);
    for (int a = 1; a < 6; a++) rd(a[2:0], 5'h00);
    $display("reset test done");
    foreach (ml[j]) begin
      mode = ml[j];
      for (int i = 0; i < 3; i++) begin
        m1  = 5'($random(seed));
        m2  = 5'($random(seed));
        pre = {4'($random(seed)), 1'b1};
        cfg();
        rd(3'h2, m1);
      end
    end
    mode = 4'h8;
    m1   = 5'h10;
    m2   = 5'h1F;
    pre  = 5'h01;
    cfg();
    $display("harmonic test done");
    mode = 4'h5;
    foreach (dc[j]) begin
      m1 = dc[j];
      m2 = dc[3-j];
      cfg();
    end
    pre = 5'h1E;
    cfg();
    master = 1'b0;
    en1    = 1'b0;
    cfg();
    master = 1'b1;
    en1    = 1'b1;
    $display("data test done");
    m1 = 5'h1F;
    m2 = 5'h1F;
    pre = {4'($random(seed)), 1'b1};
    cfg();
    mode = 4'h6;
    m2 = 5'h0E;
    cfg();
    m2 = 5'h1F;
    pre = {4'($random(seed)), 1'b1};
    cfg();
    rd(3'h3, 5'h1F);
    chk_sync(2240);
    $display("reverse test done");
    print_verdict();
  end
endmodule

// File: design/dpdc_harmonic.sv
// Harmonic decode for one PLL: K factor and output rate in 100 Hz units.
// Assumes code, rate and enable come from logic on the reference clock.
`timescale 1ns/1ps
module dpdc_harmonic #(
  parameter int CODE_W = 5,
  parameter int FREQ_W = 16
) (
  // Clock and reset
  input  wire logic              i_ref_clk,
  input  wire logic              i_rst_b,
  // Setting
  input  wire logic              i_enable,
  input  wire logic [CODE_W-1:0] i_code,
  input  dpdc_pkg::dpdc_rate_e   i_rate,
  // Result
  output logic [CODE_W:0]        o_k,
  output logic [FREQ_W-1:0]      o_freq
);
  import dpdc_pkg::*;

  logic [CODE_W:0]   k_d;
  logic [CODE_W-1:0] data_code;
  logic [FREQ_W-1:0] freq_d;

  assign k_d       = {1'b0, i_code} + 1'b1;
  assign data_code = (i_code > DATA_SAT_CODE) ? DATA_SAT_CODE : i_code;

  always_comb begin
    freq_d = '0;
    if (i_enable) begin
      case (i_rate)
        RATE_K56:  freq_d = FREQ_W'(k_d * LOW56_KHZ * FREQ_SCALE);
        RATE_K64:  freq_d = FREQ_W'(k_d * LOW64_KHZ * FREQ_SCALE);
        RATE_DATA: begin
          if (i_code == '0) begin
            freq_d = FREQ_W'(DATA_FIRST);
          end else begin
            freq_d = FREQ_W'(data_code * DATA_STEP);
          end
        end
        RATE_T1:   freq_d = FREQ_W'(T1_BASE_KHZ * FREQ_SCALE);
        RATE_E1:   freq_d = FREQ_W'(E1_BASE_KHZ * FREQ_SCALE);
        default:   freq_d = '0;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_k    <= '0;
      o_freq <= '0;
    end else begin
      o_k    <= k_d;
      o_freq <= freq_d;
    end
  end

  a_k_plus_one:
  assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    1'b1 |=> (o_k == {1'b0, $past(i_code)} + 1'b1))
    else $error("K factor is not code plus one");

  a_data_ceiling:
  assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (i_enable && i_rate == RATE_DATA && i_code >= DATA_SAT_CODE)
    |=> (o_freq == 16'h01B0))
    else $error("Data rate not held at its ceiling");

  a_k56_rate:
  assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (i_enable && i_rate == RATE_K56 && i_code == 5'h1F)
    |=> (o_freq == 16'h4600))
    else $error("Top K56 rate wrong");

endmodule

// File: design/dpdc_pkg.sv
// Shared constants, types and decode functions for the dual PLL divider
// configuration block.
// Assumes a single 25 MHz reference clock domain in all users.
package dpdc_pkg;

  localparam int CODE_W  = 5;
  localparam int FREQ_W  = 16;
  localparam int RATIO_W = 16;
  localparam int DLY_W   = 5;
  localparam int NPIN    = 5;

  // Command register addresses on the serial port
  localparam logic [2:0] ADDR_PRESCALE = 3'h1;
  localparam logic [2:0] ADDR_MULT1    = 3'h2;
  localparam logic [2:0] ADDR_MULT2    = 3'h3;

  // Values after reset
  localparam logic [4:0]      RST_PRESCALE = 5'h00;
  localparam logic [4:0]      RST_MULT1    = 5'h00;
  localparam logic [4:0]      RST_MULT2    = 5'h00;
  localparam logic [NPIN-1:0] PIN_RST      = 5'h01;

  // Field positions
  localparam int PRE_EN_BIT    = 0;
  localparam int PRE_RATIO_LSB = 1;
  localparam int PRE_RATIO_MSB = 4;

  // Serial frame: header bits, then frame length in rising edges
  localparam logic [4:0] HDR_BITS   = 5'h08;
  localparam logic [4:0] FRAME_BITS = 5'h10;

  // Rates in kHz
  localparam logic [15:0] T1_BASE_KHZ = 16'h0608;
  localparam logic [15:0] E1_BASE_KHZ = 16'h0800;
  localparam logic [15:0] SYNC_KHZ    = 16'h0008;
  localparam logic [15:0] LOW56_KHZ   = 16'h0038;
  localparam logic [15:0] LOW64_KHZ   = 16'h0040;

  // Output rates are reported in 100 Hz units
  localparam logic [15:0] FREQ_SCALE    = 16'h000A;
  localparam logic [15:0] DATA_FIRST    = 16'h000C;
  localparam logic [15:0] DATA_STEP     = 16'h0018;
  localparam logic [4:0]  DATA_SAT_CODE = 5'h12;

  // Reference clock period, ns
  localparam logic [9:0] REF_PERIOD_NS = 10'h028;

  // Sync to clock edge delay in ns, indexed by first multiplier code
  localparam logic [9:0] DLY56_NS [32] = '{
    10'h174, 10'h174, 10'h174, 10'h174, 10'h1BE, 10'h174, 10'h13F, 10'h117,
    10'h1F0, 10'h1BE, 10'h196, 10'h174, 10'h157, 10'h13F, 10'h12A, 10'h117,
    10'h20D, 10'h1F0, 10'h1D6, 10'h1BE, 10'h1A9, 10'h196, 10'h184, 10'h174,
    10'h165, 10'h157, 10'h14B, 10'h13F, 10'h134, 10'h12A, 10'h120, 10'h117};
  localparam logic [9:0] DLY64_NS [32] = '{
    10'h146, 10'h146, 10'h146, 10'h146, 10'h187, 10'h146, 10'h117, 10'h0F4,
    10'h1B2, 10'h12D, 10'h163, 10'h146, 10'h12D, 10'h117, 10'h104, 10'h0F4,
    10'h1CC, 10'h1B2, 10'h19B, 10'h187, 10'h174, 10'h163, 10'h154, 10'h146,
    10'h138, 10'h12D, 10'h121, 10'h117, 10'h117, 10'h104, 10'h0FC, 10'h0F4};

  typedef enum logic [4:0] {
    RATE_K56  = 5'b00001,
    RATE_K64  = 5'b00010,
    RATE_DATA = 5'b00100,
    RATE_T1   = 5'b01000,
    RATE_E1   = 5'b10000
  } dpdc_rate_e;

  typedef enum logic [4:0] {
    IN_T1 = 5'b00001,
    IN_E1 = 5'b00010,
    IN_56 = 5'b00100,
    IN_64 = 5'b01000,
    IN_8K = 5'b10000
  } dpdc_input_e;

  // Output kind of one PLL from the operating mode field
  function automatic dpdc_rate_e dpdc_rate(input logic [3:0] mode,
                                           input logic       second);
    dpdc_rate_e r;
    r = RATE_K56;
    case (mode[2:0])
      3'h0: r = RATE_K56;
      3'h1: r = second ? RATE_K64 : RATE_K56;
      3'h2: r = RATE_K64;
      3'h3: r = second ? RATE_DATA : RATE_K56;
      3'h4: r = second ? RATE_DATA : RATE_K64;
      3'h5: r = RATE_DATA;
      3'h6: r = (mode[3] && second) ? RATE_E1 : RATE_T1;
      3'h7: r = (mode[3] || second) ? RATE_E1 : RATE_T1;
      default: r = RATE_K56;
    endcase
    return r;
  endfunction

  // Kind of reference expected on the input pin
  function automatic dpdc_input_e dpdc_input(input logic [3:0] mode);
    dpdc_input_e r;
    r = mode[3] ? IN_E1 : IN_T1;
    if (mode[2:1] == 2'h3) begin
      case (mode[3:0])
        4'h6:    r = IN_56;
        4'hF:    r = IN_64;
        default: r = IN_8K;
      endcase
    end
    return r;
  endfunction

endpackage

// File: design/dpdc_prescaler.sv
// Prescaler: counts reference edges and forms the 8 kHz sync square wave.
// Assumes the edge pulse and level are already synchronised.
`timescale 1ns/1ps
module dpdc_prescaler #(
  parameter int RATIO_W = 16
) (
  // Clock and reset
  input  wire logic               i_ref_clk,
  input  wire logic               i_rst_b,
  // Reference input
  input  wire logic               i_fin_level,
  input  wire logic               i_fin_rise,
  input  wire logic [RATIO_W-1:0] i_ratio,
  // Sync output
  output logic                    o_sync
);
  logic [RATIO_W-1:0] cnt_q;
  logic [RATIO_W-1:0] half;
  logic               last;

  assign last = (cnt_q >= i_ratio - 1'b1);
  assign half = (i_ratio + 1'b1) >> 1;

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_q <= '0;
    end else if (i_fin_rise) begin
      cnt_q <= last ? '0 : cnt_q + 1'b1;
    end
  end

  // Ratio of one passes the reference straight through
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_sync <= 1'b0;
    end else if (i_ratio == RATIO_W'(1)) begin
      o_sync <= i_fin_level;
    end else begin
      o_sync <= (cnt_q < half);
    end
  end

  a_count_wrap:
  assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (i_fin_rise && cnt_q == i_ratio - 1'b1) |=> (cnt_q == '0))
    else $error("Prescaler did not wrap at its ratio");

  c_sync_wrap: cover property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    i_fin_rise && last && i_ratio > RATIO_W'(1));

endmodule

// File: design/dpdc_top.sv
// Dual PLL divider configuration: serial command port, prescaler and
// multiplier registers, per-PLL rate decode and the 8 kHz sync divider.
// Assumes serial pins, reference and master strap are asynchronous pins;
// mode field and first PLL enable come from logic on the same clock.
`timescale 1ns/1ps
// Notes on behaviour
// - Enable bit runs second PLL, else disabled.
// - Prescaler divides reference down to 8 kHz.
// - Forward prescaler multiple is code plus one.
// - Prescaler code ignored in reverse mode.
// - First PLL K is code plus one.
// - First PLL gives K times 56 or 64.
// - Data mode steps 2.4 kHz, saturates 43.2.
// - First multiplier sets sync to clock delay.
// - Harmonic mapping unused in master reverse mode.
// - Second PLL K is its code plus one.
// - Second PLL data mode follows same sequence.
// - All three registers zero after reset.
// - Each PLL takes K from own register.
// - Mode field selects how settings are read.
module dpdc_top (
  // Clock and reset
  input  wire logic                        i_ref_clk,
  input  wire logic                        i_rst_b,
  // Serial command port
  input  wire logic                        i_csb_b,
  input  wire logic                        i_sclk,
  input  wire logic                        i_sdi,
  output logic                             o_sdo,
  output logic                             o_sdo_oe_b,
  // Reference and strap pins
  input  wire logic                        i_fin,
  input  wire logic                        i_master_sel,
  // From the mode register
  input  wire logic [3:0]                  i_operating_mode_field,
  input  wire logic                        i_first_pll_enable,
  // Settings for the synthesiser
  output logic                             o_second_pll_enable,
  output logic [dpdc_pkg::RATIO_W-1:0]     o_prescaler_ratio,
  output logic                             o_sync,
  output dpdc_pkg::dpdc_rate_e             o_first_pll_rate,
  output dpdc_pkg::dpdc_rate_e             o_second_pll_rate,
  output logic [dpdc_pkg::CODE_W:0]        o_first_pll_k,
  output logic [dpdc_pkg::CODE_W:0]        o_second_pll_k,
  output logic [dpdc_pkg::FREQ_W-1:0]      o_first_pll_freq,
  output logic [dpdc_pkg::FREQ_W-1:0]      o_second_pll_freq,
  output logic [dpdc_pkg::DLY_W-1:0]       o_sync_delay_cyc,
  output logic                             o_reverse_cfg_err
);
  import dpdc_pkg::*;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_HDR  = 5'b00010,
    ST_WR   = 5'b00100,
    ST_RD   = 5'b01000,
    ST_DONE = 5'b10000
  } dpdc_state_e;

  logic [NPIN-1:0]    pin_raw;
  logic [NPIN-1:0]    meta_q;
  logic [NPIN-1:0]    sync_q;
  logic               sclk_prev_q;
  logic               fin_prev_q;
  logic               csb_s;
  logic               sclk_s;
  logic               sdi_s;
  logic               fin_s;
  logic               master_s;
  logic               sclk_rise;
  logic               sclk_fall;
  logic               fin_rise;
  dpdc_state_e        state_q;
  logic [4:0]         bit_cnt_q;
  logic [7:0]         hdr_q;
  logic [7:0]         wdat_q;
  logic [7:0]         rd_shift_q;
  logic [7:0]         rd_word;
  logic [2:0]         addr;
  logic               addr_ok;
  logic               wr_commit;
  logic [CODE_W-1:0]  prescale_q;
  logic [CODE_W-1:0]  mult1_q;
  logic [CODE_W-1:0]  mult2_q;
  logic               wrote_q;
  logic               reverse;
  dpdc_input_e        in_kind;
  logic [15:0]        pre_n;
  logic [RATIO_W-1:0] ratio_d;
  dpdc_rate_e         rate_d [2];
  logic [CODE_W-1:0]  code_arr [2];
  logic               en_arr [2];
  logic [CODE_W:0]    k_arr [2];
  logic [FREQ_W-1:0]  freq_arr [2];
  logic [9:0]         dly_ns_d;

  // Pin synchronisers
  assign pin_raw = {i_master_sel, i_fin, i_sdi, i_sclk, i_csb_b};

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta_q <= PIN_RST;
      sync_q <= PIN_RST;
    end else begin
      meta_q <= pin_raw;
      sync_q <= meta_q;
    end
  end

  assign csb_s    = sync_q[0];
  assign sclk_s   = sync_q[1];
  assign sdi_s    = sync_q[2];
  assign fin_s    = sync_q[3];
  assign master_s = sync_q[4];

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sclk_prev_q <= 1'b0;
      fin_prev_q  <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_s;
      fin_prev_q  <= fin_s;
    end
  end

  assign sclk_rise = sclk_s && !sclk_prev_q;
  assign sclk_fall = !sclk_s && sclk_prev_q;
  assign fin_rise  = fin_s && !fin_prev_q;

  // Serial frame sequencing; chip select high aborts any frame
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q   <= ST_IDLE;
      bit_cnt_q <= '0;
    end else if (csb_s) begin
      state_q   <= ST_IDLE;
      bit_cnt_q <= '0;
    end else begin
      case (state_q)
        ST_IDLE: state_q <= ST_HDR;
        ST_HDR: begin
          if (bit_cnt_q == HDR_BITS) begin
            state_q <= hdr_q[0] ? ST_RD : ST_WR;
          end else if (sclk_rise) begin
            bit_cnt_q <= bit_cnt_q + 1'b1;
          end
        end
        ST_WR: begin
          if (bit_cnt_q == FRAME_BITS) begin
            state_q <= ST_DONE;
          end else if (sclk_rise) begin
            bit_cnt_q <= bit_cnt_q + 1'b1;
          end
        end
        ST_RD:   state_q <= ST_RD;
        ST_DONE: state_q <= ST_DONE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Header and write data arrive LSB first
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      hdr_q  <= '0;
      wdat_q <= '0;
    end else if (sclk_rise && state_q == ST_HDR && bit_cnt_q < HDR_BITS) begin
      hdr_q <= {sdi_s, hdr_q[7:1]};
    end else if (sclk_rise && state_q == ST_WR && bit_cnt_q < FRAME_BITS) begin
      wdat_q <= {sdi_s, wdat_q[7:1]};
    end
  end

  // Upper address bits must be low, else the access is ignored
  assign addr      = hdr_q[3:1];
  assign addr_ok   = (hdr_q[6:4] == 3'h0);
  assign wr_commit = (state_q == ST_WR) && (bit_cnt_q == FRAME_BITS)
                     && !csb_s && addr_ok;

  always_comb begin
    rd_word = '0;
    if (addr_ok) begin
      case (addr)
        ADDR_PRESCALE: rd_word = {3'h0, prescale_q};
        ADDR_MULT1:    rd_word = {3'h0, mult1_q};
        ADDR_MULT2:    rd_word = {3'h0, mult2_q};
        default:       rd_word = '0;
      endcase
    end
  end

  // Read data leaves on falling edges from the ninth clock onward
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rd_shift_q <= '0;
      o_sdo      <= 1'b0;
      o_sdo_oe_b <= 1'b1;
    end else if (csb_s) begin
      o_sdo      <= 1'b0;
      o_sdo_oe_b <= 1'b1;
    end else if (state_q == ST_HDR && bit_cnt_q == HDR_BITS) begin
      rd_shift_q <= rd_word;
    end else if (state_q == ST_RD && sclk_fall) begin
      o_sdo      <= rd_shift_q[0];
      o_sdo_oe_b <= 1'b0;
      rd_shift_q <= {1'b0, rd_shift_q[7:1]};
    end
  end

  // Command registers
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      prescale_q <= RST_PRESCALE;
      mult1_q    <= RST_MULT1;
      mult2_q    <= RST_MULT2;
    end else if (wr_commit) begin
      case (addr)
        ADDR_PRESCALE: prescale_q <= wdat_q[CODE_W-1:0];
        ADDR_MULT1:    mult1_q    <= wdat_q[CODE_W-1:0];
        ADDR_MULT2:    mult2_q    <= wdat_q[CODE_W-1:0];
        default:       prescale_q <= prescale_q;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wrote_q <= 1'b0;
    end else if (wr_commit) begin
      wrote_q <= 1'b1;
    end
  end

  // Mode decode and prescaler ratio
  assign reverse = (i_operating_mode_field[2:1] == 2'h3);
  assign in_kind = dpdc_input(i_operating_mode_field);
  assign pre_n   = {12'h000, prescale_q[PRE_RATIO_MSB:PRE_RATIO_LSB]}
                   + 16'h0001;

  always_comb begin
    ratio_d = SYNC_KHZ / SYNC_KHZ;
    if (master_s) begin
      case (in_kind)
        IN_T1:   ratio_d = T1_BASE_KHZ * pre_n / SYNC_KHZ;
        IN_E1:   ratio_d = E1_BASE_KHZ * pre_n / SYNC_KHZ;
        IN_56:   ratio_d = LOW56_KHZ / SYNC_KHZ;
        IN_64:   ratio_d = LOW64_KHZ / SYNC_KHZ;
        default: ratio_d = SYNC_KHZ / SYNC_KHZ;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_prescaler_ratio   <= SYNC_KHZ / SYNC_KHZ;
      o_second_pll_enable <= 1'b0;
      o_first_pll_rate    <= RATE_K56;
      o_second_pll_rate   <= RATE_K56;
      o_reverse_cfg_err   <= 1'b0;
    end else begin
      o_prescaler_ratio   <= ratio_d;
      o_second_pll_enable <= prescale_q[PRE_EN_BIT];
      o_first_pll_rate    <= rate_d[0];
      o_second_pll_rate   <= rate_d[1];
      o_reverse_cfg_err   <= reverse && !(&mult1_q && &mult2_q);
    end
  end

  dpdc_prescaler #(
    .RATIO_W (RATIO_W)
  ) u_prescaler (
    .i_ref_clk   (i_ref_clk),
    .i_rst_b     (i_rst_b),
    .i_fin_level (fin_s),
    .i_fin_rise  (fin_rise),
    .i_ratio     (o_prescaler_ratio),
    .o_sync      (o_sync)
  );

  // Per PLL harmonic decode, each from its own register
  assign code_arr[0] = mult1_q;
  assign code_arr[1] = mult2_q;
  assign en_arr[0]   = i_first_pll_enable;
  assign en_arr[1]   = prescale_q[PRE_EN_BIT];

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_pll
      assign rate_d[gi] = dpdc_rate(i_operating_mode_field, gi == 1);
      dpdc_harmonic #(
        .CODE_W (CODE_W),
        .FREQ_W (FREQ_W)
      ) u_harmonic (
        .i_ref_clk (i_ref_clk),
        .i_rst_b   (i_rst_b),
        .i_enable  (en_arr[gi]),
        .i_code    (code_arr[gi]),
        .i_rate    (rate_d[gi]),
        .o_k       (k_arr[gi]),
        .o_freq    (freq_arr[gi])
      );
    end
  endgenerate

  assign o_first_pll_k     = k_arr[0];
  assign o_second_pll_k    = k_arr[1];
  assign o_first_pll_freq  = freq_arr[0];
  assign o_second_pll_freq = freq_arr[1];

  // Sync to clock delay, only for K56 and K64 on the first PLL
  always_comb begin
    case (rate_d[0])
      RATE_K56: dly_ns_d = DLY56_NS[mult1_q];
      RATE_K64: dly_ns_d = DLY64_NS[mult1_q];
      default:  dly_ns_d = '0;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_sync_delay_cyc <= '0;
    end else begin
      o_sync_delay_cyc <= DLY_W'((dly_ns_d + REF_PERIOD_NS - 10'h001)
                                 / REF_PERIOD_NS);
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);

  a_pll2_enable:
  assert property (wr_commit && addr == ADDR_PRESCALE
    |=> ##1 (o_second_pll_enable == $past(wdat_q[PRE_EN_BIT], 2)))
    else $error("Second PLL enable did not follow write");

  a_fwd_ratio:
  assert property (master_s && in_kind == IN_T1
    |=> (o_prescaler_ratio == $past(pre_n) * 16'h00C1))
    else $error("Forward prescaler ratio wrong");

  a_code_zero:
  assert property (master_s && in_kind == IN_E1 && prescale_q[4:1] == 4'h0
    |=> (o_prescaler_ratio == 16'h0100))
    else $error("Prescaler code zero not one times base");

  a_rev_ignore:
  assert property (master_s && in_kind == IN_56
    |=> (o_prescaler_ratio == 16'h0007))
    else $error("Reverse ratio depends on code");

  a_reset_zero:
  assert property (!wrote_q
    |-> (prescale_q == '0 && mult1_q == '0 && mult2_q == '0))
    else $error("Registers not zero before first write");

  a_k_indep:
  assert property (wr_commit && addr == ADDR_MULT1 |=> $stable(mult2_q))
    else $error("Second multiplier moved on first write");

  a_delay_map:
  assert property (rate_d[0] == RATE_K56 && mult1_q == 5'h10
    |=> (o_sync_delay_cyc == 5'h0E))
    else $error("Sync delay for K17 wrong");

  a_rev_fixed:
  assert property (rate_d[0] == RATE_T1 && i_first_pll_enable
    |=> (o_first_pll_freq == 16'h3C50))
    else $error("Reverse rate not fixed");

  a_mult_live:
  assert property (wr_commit && addr == ADDR_MULT2
    |=> (mult2_q == $past(wdat_q[CODE_W-1:0]))
    ##1 (o_second_pll_k == {1'b0, mult2_q} + 1'b1))
    else $error("Multiplier write not applied");

  a_sdo_release:
  assert property (csb_s |=> o_sdo_oe_b)
    else $error("Serial output driven outside frame");

  c_write_frame: cover property (wr_commit);
  c_read_frame: cover property (state_q == ST_RD && !o_sdo_oe_b);
  c_reverse_mode: cover property (reverse && !o_reverse_cfg_err);
  c_data_mode: cover property (rate_d[1] == RATE_DATA && en_arr[1]);

endmodule
